// file: design/sll_pkg.sv
package sll_pkg;

  // Serial word geometry
  localparam int unsigned WORD_W = 24;
  localparam int unsigned SEL_W = 2;

  // Monitor source field inside the function settings word
  localparam int unsigned MON_LSB = 4;
  localparam int unsigned MON_W = 3;
  localparam logic [MON_W-1:0] MON_LOCK = 3'h1;

  // Timing: core clock and fastest serial clock, both in MHz
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned SCLK_MAX_MHZ = 20;
  // Core cycles per serial clock period at the fastest rate, rounded down
  localparam int unsigned SCLK_MIN_CYC = CORE_CLK_MHZ / SCLK_MAX_MHZ;

  // Reset values
  localparam logic [WORD_W-1:0] LATCH_RST = 24'h00_0000;
  localparam logic [2:0] SEEN_NONE = 3'h0;
  localparam logic [2:0] SEEN_ALL = 3'h7;

  // Latch selected by the last two bits shifted in
  typedef enum logic [SEL_W-1:0] {
    SEL_REF = 2'h0,
    SEL_AB = 2'h1,
    SEL_FUNC = 2'h2,
    SEL_INIT = 2'h3
  } sll_sel_e;

  // Three-wire serial pins as seen by the device
  typedef struct packed {
    logic sclk;
    logic data;
    logic strobe;
  } sll_ser_s;

  // Loaded latch contents
  typedef struct packed {
    logic [WORD_W-1:0] ref_cnt;
    logic [WORD_W-1:0] ab_cnt;
    logic [WORD_W-1:0] func;
  } sll_latch_s;

endpackage

// file: design/sll_rise_det.sv
`timescale 1ns/10ps
`default_nettype none
module sll_rise_det (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_sig,
  output logic o_rise
);
  logic prev;

  always_ff @(posedge i_core_clk) begin
    // Track the pin in reset, so a level high at release is no edge
    if (i_srst) begin
      prev <= i_sig;
    end else begin
      prev <= i_sig;
    end
  end

  assign o_rise = i_sig & ~prev;
endmodule
`default_nettype wire

// file: design/sll_latch_loader.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: Each rising serial clock edge shifts one data bit into the register.
// R2: A rising load strobe moves the last 24 shifted bits into a latch.
// R3: The port is write-only; no latch content leaves on the serial lines.
// R4: The host keeps the serial clock at or below 20 MHz.
// R5: The host holds the strobe low while a new word is shifted in.
// R6: The host sends each word as 24 bits, possibly as three bytes.
// R7: The host raises the strobe after the last byte to finish the load.
// R8: An SPI host uses clock phase zero so data is valid at the rising edge.
// R9: After power-up the output waits for reference, AB and init writes.
// R10: The monitor can present lock indication; power-down is host-driven.
// R11: The last two bits route: 00 reference, 01 AB, 10 function, 11 init.
// R12: Init sets the function word and pulses reset, once more on next AB.
// R13: A low chip enable powers the device down at once, with no clock edge.
// R14: Words arrive most significant bit first, so the select bits come last.
module sll_latch_loader
  import sll_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire sll_pkg::sll_ser_s i_ser,
  input wire logic i_chip_enable,
  input wire logic i_lock_indication,
  output var sll_pkg::sll_latch_s o_latch,
  output logic o_counter_reset,
  output logic o_output_active,
  output logic o_power_down,
  output logic o_monitor
);
  import sll_pkg::*;

  // Sampling of the serial clock needs two core cycles per half period
  if (SCLK_MIN_CYC < 4) begin : g_rate_check
    $error("Core clock too slow to sample the serial clock");
  end

  logic sclk_rise;
  logic strobe_rise;
  logic [WORD_W-1:0] shreg;
  logic init_pending;
  logic [2:0] seen;
  sll_sel_e sel;
  logic load;

  assign sel = sll_sel_e'(shreg[SEL_W-1:0]);
  assign load = strobe_rise;

  sll_rise_det u_sclk_det (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_sig(i_ser.sclk),
    .o_rise(sclk_rise)
  );

  sll_rise_det u_strobe_det (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_sig(i_ser.strobe),
    .o_rise(strobe_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input shift register

  // R1: shift on rise
  // R14: MSB first shifting
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      shreg <= LATCH_RST;
    end else if (sclk_rise) begin
      shreg <= {shreg[WORD_W-2:0], i_ser.data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch transfer

  // R2: transfer on strobe
  // R11: route by select bits
  // R3: latches only feed the core
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_latch <= {LATCH_RST, LATCH_RST, LATCH_RST};
    end else if (load) begin
      case (sel)
        SEL_REF: begin
          o_latch.ref_cnt <= shreg;
        end
        SEL_AB: begin
          o_latch.ab_cnt <= shreg;
        end
        SEL_FUNC, SEL_INIT: begin
          o_latch.func <= shreg;
        end
        default: begin
          o_latch.func <= o_latch.func;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter reset pulse

  // R12: init arms one repeat
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      init_pending <= 1'b0;
    end else if (load && sel == SEL_INIT) begin
      init_pending <= 1'b1;
    end else if (load && sel == SEL_AB) begin
      init_pending <= 1'b0;
    end
  end

  // R12: one-cycle reset pulse
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_counter_reset <= 1'b0;
    end else begin
      o_counter_reset <= load &&
        (sel == SEL_INIT || (sel == SEL_AB && init_pending));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enable after power-up programming

  // R9: track required writes
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      seen <= SEEN_NONE;
    end else if (load) begin
      case (sel)
        SEL_REF: begin
          seen[0] <= 1'b1;
        end
        SEL_AB: begin
          seen[1] <= 1'b1;
        end
        SEL_INIT: begin
          seen[2] <= 1'b1;
        end
        default: begin
          seen <= seen;
        end
      endcase
    end
  end

  // R9: active once all seen
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_output_active <= 1'b0;
    end else begin
      o_output_active <= (seen == SEEN_ALL) && i_chip_enable;
    end
  end

  // R13: immediate power-down
  // Combinational on purpose: waiting for a core edge would delay shutdown
  assign o_power_down = ~i_chip_enable;

  // R10: monitor shows lock
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_monitor <= 1'b0;
    end else begin
      o_monitor <= (o_latch.func[MON_LSB +: MON_W] == MON_LOCK) &&
        i_lock_indication;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_init_load;
    load && sel == SEL_INIT;
  endsequence

  sequence s_ab_load;
    load && sel == SEL_AB;
  endsequence

  property p_init_then_ab;
    @(posedge i_core_clk) disable iff (i_srst)
      first_match(s_init_load ##[1:1000] s_ab_load) |=> o_counter_reset;
  endproperty

  a_shift_on_rise: assert property ( // R1
    @(posedge i_core_clk) disable iff (i_srst)
    sclk_rise |=> shreg == {$past(shreg[WORD_W-2:0]), $past(i_ser.data)})
    else $error("Serial bit not shifted on rising clock");

  a_shift_hold: assert property ( // R1
    @(posedge i_core_clk) disable iff (i_srst)
    !sclk_rise |=> $stable(shreg))
    else $error("Shift register moved without clock edge");

  a_route_ref: assert property ( // R11
    @(posedge i_core_clk) disable iff (i_srst)
    load && sel == SEL_REF |=> o_latch.ref_cnt == $past(shreg)
      && $stable(o_latch.ab_cnt) && $stable(o_latch.func))
    else $error("Reference word misrouted");

  a_route_ab: assert property ( // R11
    @(posedge i_core_clk) disable iff (i_srst)
    load && sel == SEL_AB |=> o_latch.ab_cnt == $past(shreg)
      && $stable(o_latch.ref_cnt) && $stable(o_latch.func))
    else $error("AB word misrouted");

  a_route_func: assert property ( // R2
    @(posedge i_core_clk) disable iff (i_srst)
    load && (sel == SEL_FUNC || sel == SEL_INIT)
      |=> o_latch.func == $past(shreg))
    else $error("Function word not loaded");

  a_init_pulse: assert property ( // R12
    @(posedge i_core_clk) disable iff (i_srst)
    s_init_load |=> o_counter_reset ##1 !o_counter_reset)
    else $error("Init load gave no single reset pulse");

  a_ab_repeat: assert property (p_init_then_ab) // R12
    else $error("First AB load after init gave no pulse");

  a_pulse_cause: assert property ( // R12
    @(posedge i_core_clk) disable iff (i_srst)
    o_counter_reset |-> $past(load) && ($past(sel) == SEL_INIT ||
      ($past(sel) == SEL_AB && $past(init_pending))))
    else $error("Reset pulse without cause");

  a_active_gate: assert property ( // R9
    @(posedge i_core_clk) disable iff (i_srst)
    o_output_active |-> $past(seen) == SEEN_ALL && $past(i_chip_enable))
    else $error("Output active before all writes");

  a_pd_blocks: assert property ( // R13
    @(posedge i_core_clk) disable iff (i_srst)
    o_power_down |=> !o_output_active)
    else $error("Output active during power-down");

endmodule
`default_nettype wire

// file: test/sll_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sll_host_model (
  input wire logic i_core_clk,
  output var sll_pkg::sll_ser_s o_ser
);
  import sll_pkg::*;

  // Four core cycles a half period, about 15.6 MHz
  localparam int HALF = 4;

  initial o_ser = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic send_word(input logic [WORD_W-1:0] w);
    o_ser.strobe = 1'b0;
    // one 24-bit word, top bit first
    for (int i = WORD_W - 1; i >= 0; i--) begin
      o_ser.data = w[i];
      tick(HALF);
      // data settled before a slow rise
      o_ser.sclk = 1'b1;
      tick(HALF);
      o_ser.sclk = 1'b0;
    end
    // Released line shows the inverse, never a held bit
    o_ser.data = ~w[0];
    tick(HALF);
    // strobe raised after the last bit
    o_ser.strobe = 1'b1;
    tick(HALF);
    o_ser.strobe = 1'b0;
    tick(HALF);
  endtask
endmodule
`default_nettype wire

// file: test/synth_serial_latch_loader_bench.sv
`timescale 1ns/10ps
`default_nettype none
module synth_serial_latch_loader_bench;
  import sll_pkg::*;

  logic clk;
  logic srst;
  logic ce;
  logic lock;
  sll_ser_s ser;
  sll_latch_s latch;
  logic crst;
  logic act;
  logic pd;
  logic mon;
  int n_errors;
  int total_checks;
  int cycles;
  int pulses;

  sll_host_model HOST (
    .i_core_clk(clk),
    .o_ser(ser)
  );

  sll_latch_loader DUT (
    .i_core_clk(clk),
    .i_srst(srst),
    .i_ser(ser),
    .i_chip_enable(ce),
    .i_lock_indication(lock),
    .o_latch(latch),
    .o_counter_reset(crst),
    .o_output_active(act),
    .o_power_down(pd),
    .o_monitor(mon)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Whole run needs about 1450 cycles
  always @(posedge clk) begin
    cycles++;
    if (crst === 1'b1) begin
      pulses++;
    end
    if (cycles == 6000) begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [WORD_W-1:0] got,
                          input logic [WORD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_word(latch.func, LATCH_RST);
    chk_word(latch.ref_cnt, LATCH_RST);
    chk_bit(act, 1'b0);
    chk_bit(crst, 1'b0);
  endtask

  task automatic t_init();
    HOST.send_word(24'hA5_0013);
    chk_word(latch.func, 24'hA5_0013);
    chk_word(WORD_W'(pulses), 24'h00_0001);
    chk_bit(act, 1'b0);
    chk_bit(mon, 1'b0);
    lock = 1'b1;
    tick(3);
    chk_bit(mon, 1'b1);
  endtask

  task automatic t_ref_ab();
    HOST.send_word(24'h12_3450);
    chk_word(latch.ref_cnt, 24'h12_3450);
    chk_word(WORD_W'(pulses), 24'h00_0001);
    chk_bit(act, 1'b0);
    HOST.send_word(24'h65_4321);
    chk_word(latch.ab_cnt, 24'h65_4321);
    chk_word(WORD_W'(pulses), 24'h00_0002);
    chk_bit(act, 1'b1);
    HOST.send_word(24'h0F_0F05);
    chk_word(latch.ab_cnt, 24'h0F_0F05);
    chk_word(WORD_W'(pulses), 24'h00_0002);
    chk_word(latch.ref_cnt, 24'h12_3450);
  endtask

  task automatic t_func();
    HOST.send_word(24'h80_0006);
    chk_word(latch.func, 24'h80_0006);
    chk_word(WORD_W'(pulses), 24'h00_0002);
    tick(3);
    chk_bit(mon, 1'b0);
  endtask

  task automatic t_pd();
    ce = 1'b0;
    #1;
    chk_bit(pd, 1'b1);
    tick(3);
    chk_bit(act, 1'b0);
    ce = 1'b1;
    #1;
    chk_bit(pd, 1'b0);
    tick(3);
    chk_bit(act, 1'b1);
  endtask

  // Second power-up: outputs idle again, init pulse repeats on the next AB load
  task automatic t_rerun();
    srst = 1'b1;
    tick(5);
    srst = 1'b0;
    chk_bit(act, 1'b0);
    chk_word(latch.ab_cnt, LATCH_RST);
    HOST.send_word(24'h00_0103);
    chk_word(WORD_W'(pulses), 24'h00_0003);
    HOST.send_word(24'h00_0201);
    chk_word(latch.ab_cnt, 24'h00_0201);
    chk_word(WORD_W'(pulses), 24'h00_0004);
    chk_bit(act, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    lock = 1'b0;
    tick(5);
    srst = 1'b0;
    t_reset();
    t_init();
    t_ref_ab();
    t_func();
    t_pd();
    t_rerun();
    wrap_up();
  end
endmodule
`default_nettype wire
